// ==== rtl/gpc_pkg.sv ====
// Package for the three-port GPIO block with carrier modulation.
// Assumes an 8-bit special-function register bus from the CPU core.
package gpc_pkg;

    localparam logic [7:0] ADDR_PORT0_LATCH    = 8'h80;
    localparam logic [7:0] ADDR_PORT1_LATCH    = 8'h90;
    localparam logic [7:0] ADDR_CARRIER_SELECT = 8'h9f;
    localparam logic [7:0] ADDR_PORT2_LATCH    = 8'ha0;
    localparam logic [7:0] ADDR_PORT0_PU_DIS   = 8'hb2;
    localparam logic [7:0] ADDR_PORT1_PU_DIS   = 8'hb3;
    localparam logic [7:0] ADDR_PORT2_PU_DIS   = 8'hb4;
    localparam logic [7:0] ADDR_INT_PIN_CFG    = 8'hff;

    localparam logic [7:0] RST_LATCH     = 8'hff;
    localparam logic [7:0] RST_PU_DIS    = 8'h00;
    localparam logic [7:0] RST_CARRIER   = 8'h00;
    localparam logic [7:0] RST_INT_CFG   = 8'h00;
    // Bits 7, 6 and 3 of the port 2 pull-up disable register are kept zero.
    localparam logic [7:0] PORT2_PU_MASK = 8'h37;

    // Carrier timing: half period of the 38 kHz square wave.
    localparam int CLK_HZ         = 50_000_000;
    localparam int CARRIER_HZ     = 38_000;
    localparam int CARRIER_HALF   = CLK_HZ / (2 * CARRIER_HZ);
    localparam int CARRIER_CNT_W  = 10;

    // CPU strobes for one register access.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd_latch;
        logic       rd_pin;
    } gpc_sfr_req_t;

    typedef struct packed {
        logic [7:0] p0;
        logic [7:0] p1;
        logic [7:0] p2;
    } gpc_ports_t;

    typedef struct packed {
        gpc_ports_t                 latch;
        gpc_ports_t                 pu_dis;
        logic [7:0]                 carrier_sel;
        logic [7:0]                 int_cfg;
        gpc_ports_t                 sync1;
        gpc_ports_t                 sync2;
        gpc_ports_t                 sync3;
        gpc_ports_t                 pin_lvl;
        logic [CARRIER_CNT_W-1:0]   car_cnt;
        logic                       carrier;
        logic [7:0]                 rdata;
        gpc_ports_t                 oe;
        gpc_ports_t                 pu_en;
    } gpc_state_t;

endpackage : gpc_pkg

// ==== rtl/gpc_ports.sv ====
// Three 8-bit general purpose ports with latches, pull-up control and carrier.
// Assumes CPU register strobes are one-cycle pulses on clk_sys; pins are async.
//
// Notes on behaviour
// - A register write strobe loads the addressed port latch from the bus.
// - Read-latch strobe returns the stored latch bits, not the pins.
// - Read-pin strobe returns the synchronised pin levels.
// - CPU picks latch or pin readback per instruction through the strobe used.
// - Every pin has its own weak pull-up, enabled after reset.
// - Setting a port 0 or 1 disable bit turns that pin's pull-up off.
// - Pull-up off makes the pin open drain, only pulling low.
// - A latched zero drives the pin low in both pull-up modes.
// - Open drain pin with latch one floats and reads back via pin path.
// - Selected pins output latch ORed with the 38 kHz square wave.
// - Carrier acts only while the global carrier enable input is high.
// - Carrier select bits map to P1.6,P1.5,P1.4,P1.1,P0.2,P0.7,P0.5,P0.3.
// - Port 2 disable bits 5,4,2..0 act; bits 7,6,3 stay cleared.
// - An enabled peripheral owns its pin instead of the port.
`timescale 1ns/1ps

module gpc_ports
    import gpc_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // CPU special-function register bus
    input  wire gpc_sfr_req_t sfr_req,
    output logic [7:0]        sfr_rdata,
    // Global carrier enable from the system configuration register
    input  wire logic         carrier_global_enable,
    // Peripheral ownership of pins
    input  wire gpc_ports_t   periph_own,
    input  wire gpc_ports_t   periph_out,
    input  wire gpc_ports_t   periph_oe,
    // Pins
    input  wire gpc_ports_t   pin_in,
    output gpc_ports_t        pin_out,
    output gpc_ports_t        pin_oe,
    output gpc_ports_t        pin_pullup_en,
    // Reset and external-access pin pull-ups
    output logic              reset_pin_pullup_en,
    output logic              external_access_pin_pullup_en
);

    gpc_state_t st;
    gpc_state_t next_st;

    function automatic logic [7:0] drive_oe(input logic [7:0] lat,
                                            input logic [7:0] own, input logic [7:0] p_oe);
        drive_oe = (own & p_oe) | (~own & ~lat);
    endfunction : drive_oe

    always_comb begin
        logic [7:0] car0;
        logic [7:0] car1;
        logic [7:0] eff0;
        logic [7:0] eff1;
        next_st = st;
        car0 = 8'h00;
        car1 = 8'h00;
        eff0 = 8'h00;
        eff1 = 8'h00;

        // Pins are asynchronous; a change is taken once stages two and three agree.
        next_st.sync1 = pin_in;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        if (st.sync2 == st.sync3) begin
            next_st.pin_lvl = st.sync3;
        end

        if (st.car_cnt == CARRIER_CNT_W'(CARRIER_HALF - 1)) begin
            next_st.car_cnt = '0;
            next_st.carrier = ~st.carrier;
        end else begin
            next_st.car_cnt = st.car_cnt + CARRIER_CNT_W'(1);
        end

        if (sfr_req.wr) begin
            case (sfr_req.addr)
                ADDR_PORT0_LATCH:    next_st.latch.p0 = sfr_req.wdata;
                ADDR_PORT1_LATCH:    next_st.latch.p1 = sfr_req.wdata;
                ADDR_PORT2_LATCH:    next_st.latch.p2 = sfr_req.wdata;
                ADDR_CARRIER_SELECT: next_st.carrier_sel = sfr_req.wdata;
                ADDR_PORT0_PU_DIS:   next_st.pu_dis.p0 = sfr_req.wdata;
                ADDR_PORT1_PU_DIS:   next_st.pu_dis.p1 = sfr_req.wdata;
                ADDR_PORT2_PU_DIS:   next_st.pu_dis.p2 = sfr_req.wdata & PORT2_PU_MASK;
                ADDR_INT_PIN_CFG:    next_st.int_cfg = sfr_req.wdata;
                default: ;
            endcase
        end

        next_st.rdata = 8'h00;
        if (sfr_req.rd_latch || sfr_req.rd_pin) begin
            case (sfr_req.addr)
                ADDR_PORT0_LATCH:    next_st.rdata = sfr_req.rd_pin ? st.pin_lvl.p0 : st.latch.p0;
                ADDR_PORT1_LATCH:    next_st.rdata = sfr_req.rd_pin ? st.pin_lvl.p1 : st.latch.p1;
                ADDR_PORT2_LATCH:    next_st.rdata = sfr_req.rd_pin ? st.pin_lvl.p2 : st.latch.p2;
                ADDR_CARRIER_SELECT: next_st.rdata = st.carrier_sel;
                ADDR_PORT0_PU_DIS:   next_st.rdata = st.pu_dis.p0;
                ADDR_PORT1_PU_DIS:   next_st.rdata = st.pu_dis.p1;
                ADDR_PORT2_PU_DIS:   next_st.rdata = st.pu_dis.p2;
                ADDR_INT_PIN_CFG:    next_st.rdata = st.int_cfg;
                default:             next_st.rdata = 8'h00;
            endcase
        end

        if (carrier_global_enable && st.carrier) begin
            car1[6] = st.carrier_sel[7];
            car1[5] = st.carrier_sel[6];
            car1[4] = st.carrier_sel[5];
            car1[1] = st.carrier_sel[4];
            car0[2] = st.carrier_sel[3];
            car0[7] = st.carrier_sel[2];
            car0[5] = st.carrier_sel[1];
            car0[3] = st.carrier_sel[0];
        end
        eff0 = st.latch.p0 | car0;
        eff1 = st.latch.p1 | car1;

        next_st.oe.p0 = drive_oe(eff0, periph_own.p0, periph_oe.p0);
        next_st.oe.p1 = drive_oe(eff1, periph_own.p1, periph_oe.p1);
        next_st.oe.p2 = drive_oe(st.latch.p2, periph_own.p2, periph_oe.p2);
        next_st.pu_en.p0 = ~st.pu_dis.p0;
        next_st.pu_en.p1 = ~st.pu_dis.p1;
        next_st.pu_en.p2 = ~st.pu_dis.p2;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st             <= '0;
            st.latch       <= {RST_LATCH, RST_LATCH, RST_LATCH};
            st.pu_dis      <= {RST_PU_DIS, RST_PU_DIS, RST_PU_DIS};
            st.carrier_sel <= RST_CARRIER;
            st.int_cfg     <= RST_INT_CFG;
            st.sync1       <= '1;
            st.sync2       <= '1;
            st.sync3       <= '1;
            st.pin_lvl     <= '1;
            st.pu_en       <= '1;
        end else begin
            st <= next_st;
        end
    end

    // Driven level: peripheral data where owned, otherwise low when enabled.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_out <= '0;
        end else begin
            pin_out <= periph_own & periph_out;
        end
    end

    assign sfr_rdata                     = st.rdata;
    assign pin_oe                        = st.oe;
    assign pin_pullup_en                 = st.pu_en;
    // The inverted disable bits are already registered in the pull-up enables.
    assign reset_pin_pullup_en           = st.pu_en.p2[5];
    assign external_access_pin_pullup_en = st.pu_en.p2[4];

endmodule : gpc_ports

// ==== test/gpc_ports_asserts.sv ====
// Port checker for the three-port GPIO block.
// Assumes bind into gpc_ports; the bench holds periph_own at zero on port 2.
`timescale 1ns/1ps
module gpc_ports_asserts
    import gpc_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         sys_rst,
    input wire gpc_sfr_req_t sfr_req,
    input wire logic [7:0]   sfr_rdata,
    input wire logic         carrier_global_enable,
    input wire gpc_ports_t   periph_own,
    input wire gpc_ports_t   periph_oe,
    input wire gpc_ports_t   pin_in,
    input wire gpc_ports_t   pin_oe,
    input wire gpc_ports_t   pin_pullup_en,
    input wire logic         reset_pin_pullup_en,
    input wire logic         external_access_pin_pullup_en
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic w2, wb3, wb4, rl2;
    assign w2  = sfr_req.wr && sfr_req.addr == ADDR_PORT2_LATCH;
    assign wb3 = sfr_req.wr && sfr_req.addr == ADDR_PORT1_PU_DIS;
    assign wb4 = sfr_req.wr && sfr_req.addr == ADDR_PORT2_PU_DIS;
    assign rl2 = sfr_req.rd_latch && !sfr_req.rd_pin && sfr_req.addr == ADDR_PORT2_LATCH;
    property p_drive; w2 ##1 !w2 |=> pin_oe.p2[1:0] == ~$past(sfr_req.wdata[1:0], 2); endproperty
    a_drive: assert property (p_drive) else $error("port drive mismatch");
    property p_rdl; w2 ##1 rl2 |=> sfr_rdata[1:0] == $past(sfr_req.wdata[1:0], 2); endproperty
    a_rdl: assert property (p_rdl) else $error("latch read mismatch");
    property p_rdp;
        $stable(pin_in.p2)[*6] ##0 (sfr_req.rd_pin && sfr_req.addr == ADDR_PORT2_LATCH)
            |=> sfr_rdata[1:0] == $past(pin_in.p2[1:0]);
    endproperty
    a_rdp: assert property (p_rdp) else $error("pin read mismatch");
    property p_rst; disable iff (1'b0) sys_rst |=> pin_pullup_en == '1 && pin_oe == '0; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_pu1; wb3 ##1 !wb3 |=> pin_pullup_en.p1 == ~$past(sfr_req.wdata, 2); endproperty
    a_pu1: assert property (p_pu1) else $error("pull-up control wrong");
    property p_pu2;
        wb4 ##1 !wb4 |=> {reset_pin_pullup_en, external_access_pin_pullup_en,
            pin_pullup_en.p2[2:0]} == ~{$past(sfr_req.wdata[5:4], 2), $past(sfr_req.wdata[2:0], 2)};
    endproperty
    a_pu2: assert property (p_pu2) else $error("port 2 pull-up wrong");
    property p_quiet;
        (!carrier_global_enable && !sfr_req.wr && periph_own == '0)[*3] |-> $stable(pin_oe);
    endproperty
    a_quiet: assert property (p_quiet) else $error("pin moved while idle");
    property p_own; periph_own.p0[0] |=> pin_oe.p0[0] == $past(periph_oe.p0[0]); endproperty
    a_own: assert property (p_own) else $error("peripheral lost pin");
endmodule : gpc_ports_asserts

// ==== test/gpc_pin_model.sv ====
// External parts on the pins: a driver that can pull lines low.
// Assumes a board pull-up on every line, so a released line reads high.
`timescale 1ns/1ps
module gpc_pin_model
    import gpc_pkg::*;
(
    // Device side
    input  wire gpc_ports_t pin_out,
    input  wire gpc_ports_t pin_oe,
    // External low drivers and resolved levels
    input  wire gpc_ports_t ext_low,
    output gpc_ports_t      pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_low);
endmodule : gpc_pin_model

// ==== test/gpc_ports_bench.sv ====
// Self-checking bench for gpc_ports with the pin model.
// Assumes the 50 MHz clock and the carrier half period from the package.
`timescale 1ns/1ps
module gpc_ports_bench
    import gpc_pkg::*;
;
    logic         clk_sys = 1'b0;
    logic         sys_rst = 1'b1;
    logic         car_en  = 1'b0;
    gpc_sfr_req_t req     = '0;
    gpc_ports_t   own = '0, poe = '0, pout = '0, ext = '0, pin_in, pin_out, pin_oe, pu;
    logic [7:0]   rdata;
    logic         rst_pu, ea_pu;
    logic [23:0]  oe_v;
    int           errors = 0, checked = 0, cycles = 0, n;
    int           idx[8] = '{19, 21, 23, 18, 9, 12, 13, 14};
    logic         b;
    assign oe_v = pin_oe;
    always #10 clk_sys = ~clk_sys;
    gpc_ports u_gpc_ports (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_req(req),
        .sfr_rdata(rdata), .carrier_global_enable(car_en), .periph_own(own),
        .periph_out(pout), .periph_oe(poe), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup_en(pu), .reset_pin_pullup_en(rst_pu),
        .external_access_pin_pullup_en(ea_pu));
    gpc_pin_model u_gpc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext),
        .pin_in(pin_in));
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int k);
        req = '0;
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{a, d, 1'b1, 1'b0, 1'b0};
        @(posedge clk_sys);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic p, input logic [7:0] e);
        req = '{a, 8'h00, 1'b0, !p, p};
        @(posedge clk_sys);
        #1;
        chk(24'(rdata), 24'(e));
    endtask : rd
    task automatic t_reset;
        chk(pu, 24'hffffff);
        rd(ADDR_PORT0_PU_DIS, 1'b0, 8'h00);
        rd(ADDR_CARRIER_SELECT, 1'b0, 8'h00);
        rd(ADDR_PORT1_LATCH, 1'b0, 8'hff);
        rd(8'h81, 1'b1, 8'h00);
    endtask : t_reset
    task automatic t_ports;
        ext = '{8'h00, 8'h00, 8'h02};
        wr(ADDR_PORT2_LATCH, 8'hfe);
        rd(ADDR_PORT2_LATCH, 1'b0, 8'hfe);
        chk(24'(pin_oe.p2[1:0]), 24'h1);
        cyc(6);
        rd(ADDR_PORT2_LATCH, 1'b1, 8'hfc);
        wr(ADDR_PORT2_PU_DIS, 8'hff);
        rd(ADDR_PORT2_PU_DIS, 1'b0, 8'h37);
        chk({rst_pu, ea_pu, pu.p2[2:0]}, 24'h0);
        ext = '0;
        cyc(6);
        rd(ADDR_PORT2_LATCH, 1'b1, 8'hfe);
        wr(ADDR_PORT1_PU_DIS, 8'h0f);
        cyc(1);
        chk({pu.p1, pin_oe.p1}, 24'hf000);
    endtask : t_ports
    task automatic t_carrier;
        wr(ADDR_PORT0_LATCH, 8'h00);
        wr(ADDR_PORT1_LATCH, 8'h00);
        car_en = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CARRIER_SELECT, 8'h01 << i);
            cyc(2);
            for (int j = 0; j < 2; j++) begin
                b = oe_v[idx[i]];
                n = 0;
                while (oe_v[idx[i]] === b && n < 2000) begin
                    cyc(1);
                    n++;
                end
            end
            chk(24'(n), 24'(CARRIER_HALF));
            chk(oe_v | (24'h1 << idx[i]), 24'hffff01);
        end
        car_en = 1'b0;
        cyc(3);
        chk(oe_v, 24'hffff01);
    endtask : t_carrier
    task automatic t_periph;
        wr(ADDR_PORT0_LATCH, 8'h01);
        own.p0 = 8'h01;
        pout.p0 = 8'h01;
        poe.p0 = 8'h01;
        cyc(2);
        chk({pin_oe.p0[0], pin_out.p0[0]}, 24'h3);
        poe.p0 = 8'h00;
        cyc(2);
        chk({pin_oe.p0[0], pin_out.p0[0]}, 24'h1);
    endtask : t_periph
    task automatic end_sim;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_ports();
        t_carrier();
        t_periph();
        end_sim();
    end
endmodule : gpc_ports_bench
bind gpc_ports gpc_ports_asserts u_gpc_ports_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .carrier_global_enable(carrier_global_enable),
    .periph_own(periph_own), .periph_oe(periph_oe), .pin_in(pin_in), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .reset_pin_pullup_en(reset_pin_pullup_en),
    .external_access_pin_pullup_en(external_access_pin_pullup_en));
